// ### verification/tb.sv
// Self-checking bench of the trigger step sequencer
module tb
    import tss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // =========================================================
    // Signals, instances and monitor
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_ce = 1'b1;
    tss_bus_req_t bus = '0;
    logic [15:0] rdata, trig_in, irq_req, d;
    logic [31:0] trig_out;
    logic [4:0] chsel, v, t;
    logic [3:0] r, k;
    logic irq;
    int err_count = 0, n_compared = 0, n_hit, n_irq, n_stray, h, a;
    logic [7:0] prog [14];
    logic [7:0] ra [8] = '{8'h0C, 8'h10, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h08, 8'h04};
    logic [15:0] rv [8];
    tss_step_sequencer u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_bus(bus),
        .o_rdata(rdata), .i_trig_in(trig_in), .o_trig_out(trig_out), .o_irq_req(irq_req),
        .o_adc_chsel(chsel), .o_irq(irq));
    tss_trig_src u_src (.i_clk(i_clk), .o_trig(trig_in));
    initial forever #5 i_clk = ~i_clk;
    always @(posedge i_clk)
    begin
        if (trig_out === 32'h1 << t) n_hit++;
        else if (|trig_out) n_stray++;
        if (irq_req === 16'h1 << r) n_irq++;
        else if (|irq_req) n_stray++;
    end
    // =========================================================
    // Tasks
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %s exp %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    task wr(input logic [7:0] ad, input logic [15:0] wd);
        @(posedge i_clk);
        bus <= '{ad, wd, 1'b1, 1'b0};
        @(posedge i_clk);
        bus <= '0;
    endtask : wr
    task rd(input logic [7:0] ad, output logic [15:0] q);
        @(posedge i_clk);
        bus <= '{ad, 16'h0000, 1'b0, 1'b1};
        @(posedge i_clk);
        bus <= '0;
        @(negedge i_clk);
        q = rdata;
    endtask : rd
    task rdchk(input string nm, input logic [7:0] ad, input logic [15:0] exp);
        rd(ad, d);
        chk(nm, {16'h0000, d}, {16'h0000, exp});
    endtask : rdchk
    task test_done;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    task round(input int n);
        h = $urandom_range(3);
        a = $urandom_range(3);
        v = 5'($urandom);
        t = 5'($urandom_range(30));
        r = 4'($urandom);
        k = 4'($urandom);
        prog = '{8'h18, 8'h11, {3'h1, v}, {3'h4, t}, {4'h7, r}, 8'h60, {3'h6, 5'h03},
            {3'h7, 5'h07}, {4'h4, k}, {4'h5, k}, (n == 1) ? 8'h02 : (n == 2) ? 8'h03 : 8'h05,
            {3'h5, 5'h0D}, 8'h9F, 8'h01};
        rv = '{16'(a), 16'(h), 16'h0, 16'h0, 16'h0, 16'h0, (n == 1) ? 16'h4 : 16'h0, 16'h1F};
        for (int i = 0; i < 14; i++) wr(8'h80 + 8'(4 * i), {8'h00, prog[i]});
        for (int i = 0; i < 8; i++) wr(ra[i], rv[i]);
        n_hit = 0;
        n_irq = 0;
        n_stray = 0;
        fork
            u_src.edges(k, 45, 15);
        join_none
        wr(8'h00, 16'h0001);
        repeat (28) @(posedge i_clk);
        rdchk("run_rise", 8'h00, 16'h0001);
        repeat (14) @(posedge i_clk);
        rdchk("run_fall", 8'h00, 16'h0001);
        repeat (30) @(posedge i_clk);
        rdchk("halted", 8'h00, 16'h0000);
        rd(8'h04, d);
        chk("halt_st", d[0], 1'b1);
        chk("irq_st", d[2], 1'b1);
        rdchk("lim_a", 8'h14, 16'(h));
        rdchk("lim_b", 8'h18, 16'(a));
        rdchk("cnt_a", 8'h1C, (n == 1) ? 16'h0000 : 16'(h));
        rdchk("cnt_b", 8'h20, (n == 2) ? 16'h0000 : 16'(a));
        chk("chsel", chsel, v);
        chk("trig", n_hit, h + 1);
        chk("irq_req", n_irq, h + 1);
        chk("stray", n_stray, 0);
        chk("irq", irq, n == 1);
        wr(8'h04, 16'h001F);
        @(negedge i_clk);
        chk("irq_clr", irq, 1'b0);
    endtask : round
    // =========================================================
    // Main sequence and watchdog
    initial
    begin
        void'($urandom(32'h4272B579));
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        rdchk("rst_lim", 8'h14, 16'h0000);
        chk("rst_chsel", chsel, 5'h00);
        rdchk("unmapped", 8'h40, 16'h0000);
        for (int n = 0; n < 3; n++) round(n);
        @(posedge i_clk);
        i_ce <= 1'b0;
        wr(8'h14, 16'h0007);
        i_ce <= 1'b1;
        rdchk("frozen", 8'h14, 16'(h));
        test_done;
    end
    initial
    begin
        repeat (6000) @(posedge i_clk);
        err_count++;
        test_done;
    end
endmodule : tb

// ### verification/tss_sva.sv
// Port assertions of the trigger step sequencer
module tss_sva
    import tss_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire tss_bus_req_t i_bus,
    input wire logic [DATA_W-1:0] o_rdata,
    input wire logic [NUM_TRIG_IN-1:0] i_trig_in,
    input wire logic [NUM_TRIG_OUT-1:0] o_trig_out,
    input wire logic [NUM_IRQ-1:0] o_irq_req,
    input wire logic [CHSEL_W-1:0] o_adc_chsel,
    input wire logic o_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    // =========================================================
    // Properties
    default clocking dc @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_frozen; !i_ce; endsequence
    sequence s_rd_idle; i_ce && !i_bus.rd; endsequence
    property p_trig_hot; $onehot0(o_trig_out); endproperty
    a_trig_hot: assert property (p_trig_hot) else $error("trigger out not one-hot");
    property p_irq_hot; $onehot0(o_irq_req); endproperty
    a_irq_hot: assert property (p_irq_hot) else $error("irq request not one-hot");
    property p_one_step; !(|o_trig_out && |o_irq_req); endproperty
    a_one_step: assert property (p_one_step) else $error("two step effects at once");
    property p_chsel; $changed(o_adc_chsel) |-> !(|o_trig_out) && !(|o_irq_req); endproperty
    a_chsel: assert property (p_chsel) else $error("channel select moved off a strobe");
    property p_freeze;
        s_frozen |=> $stable(o_adc_chsel) && $stable(o_trig_out) && $stable(o_irq);
    endproperty
    a_freeze: assert property (p_freeze) else $error("outputs moved while disabled");
    property p_rd_idle; s_rd_idle |=> o_rdata == '0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    property p_rst; $past(i_rst) |-> !(|o_trig_out) && o_rdata == '0 && !o_irq; endproperty
    a_rst: assert property (p_rst) else $error("outputs not clear after reset");
    property p_irq_rise; $rose(o_irq) |-> $past(i_ce); endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("interrupt rose while disabled");
endmodule : tss_sva

bind tss_step_sequencer tss_sva u_sva (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_bus(i_bus),
    .o_rdata(o_rdata), .i_trig_in(i_trig_in), .o_trig_out(o_trig_out), .o_irq_req(o_irq_req),
    .o_adc_chsel(o_adc_chsel), .o_irq(o_irq));

// ### verification/tss_trig_src.sv
// Trigger source model driving the sequencer trigger inputs
module tss_trig_src (
    input wire logic i_clk,
    output logic [15:0] o_trig
);
    timeunit 1ns;
    timeprecision 1ns;
    // =========================================================
    // Noise on unselected inputs, controlled level on the selected one
    logic [3:0] sel = 4'h0;
    logic lvl = 1'b0;
    logic [15:0] msk;
    assign msk = 16'h0001 << sel;
    always @(posedge i_clk) o_trig <= (16'($urandom) & ~msk) | (lvl ? msk : 16'h0000);
    task edges(input logic [3:0] k, input int d1, input int d2);
        sel <= k;
        lvl <= 1'b0;
        repeat (d1) @(posedge i_clk);
        lvl <= 1'b1;
        repeat (d2) @(posedge i_clk);
        lvl <= 1'b0;
    endtask : edges
endmodule : tss_trig_src

// ### verilog/tss_pkg.sv
// Constants and types of the trigger step sequencer
package tss_pkg;

    // =========================================================
    // Widths and counts
    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned QPTR_W = 5;
    localparam int unsigned QUEUE_DEPTH = 32;
    localparam int unsigned NUM_TRIG_IN = 16;
    localparam int unsigned NUM_IRQ = 16;
    localparam int unsigned NUM_TRIG_OUT = 32;
    localparam int unsigned CHSEL_W = 5;
    localparam int unsigned NUM_TGT = 4;
    localparam int unsigned NUM_EVT = 5;

    // =========================================================
    // Register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;
    localparam logic [7:0] OFS_ADJUST = 8'h0C;
    localparam logic [7:0] OFS_HOLD = 8'h10;
    localparam logic [7:0] OFS_TGT_BASE = 8'h14;
    localparam logic [7:0] OFS_TGT_STRIDE = 8'h04;
    localparam logic [7:0] OFS_QPTR = 8'h24;
    localparam logic [7:0] OFS_CHSEL = 8'h28;
    localparam int unsigned STEP_WIN_BIT = 7;

    // =========================================================
    // Field positions and reset values
    localparam int unsigned CTRL_RUN_BIT = 0;
    localparam int unsigned COPY_SEL_BIT = 3;
    localparam int unsigned TGT_LIM_A = 0;
    localparam int unsigned TGT_LIM_B = 1;
    localparam int unsigned TGT_CNT_A = 2;
    localparam int unsigned TGT_CNT_B = 3;
    localparam int unsigned EVT_HALT = 0;
    localparam int unsigned EVT_WAIT = 1;
    localparam int unsigned EVT_IRQ = 2;
    localparam int unsigned EVT_LOOP_A = 3;
    localparam int unsigned EVT_LOOP_B = 4;
    localparam logic [15:0] RST_DATA = 16'h0000;
    localparam logic [4:0] RST_QPTR = 5'h00;
    localparam logic [4:0] RST_CHSEL = 5'h00;
    localparam logic [7:0] RST_STEP = 8'h00;

    // =========================================================
    // Opcodes and control options
    localparam logic [3:0] OP_CTRL = 4'h0;
    localparam logic [3:0] OP_ADD_COPY = 4'h1;
    localparam logic [3:0] OP_WAIT_RISE = 4'h4;
    localparam logic [3:0] OP_WAIT_FALL = 4'h5;
    localparam logic [3:0] OP_IRQ = 4'h7;
    localparam logic [2:0] OPH_STROBE = 3'h1;
    localparam logic [2:0] OPH_TRIG = 3'h4;
    localparam logic [2:0] OPH_JUMP = 3'h5;
    localparam logic [2:0] OPH_LOOP_A = 3'h6;
    localparam logic [2:0] OPH_LOOP_B = 3'h7;
    localparam logic [3:0] CTL_HALT = 4'h1;
    localparam logic [3:0] CTL_CLR_A = 4'h2;
    localparam logic [3:0] CTL_CLR_B = 4'h3;

    // =========================================================
    // Types
    typedef struct packed {
        logic [3:0] opcode;
        logic [3:0] option;
    } tss_step_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } tss_bus_req_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } tss_state_t;

endpackage : tss_pkg

// ### verilog/tss_step_sequencer.sv
// Step command decoder and executor of the trigger step sequencer
// =========================================================
module tss_step_sequencer
    import tss_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire tss_bus_req_t i_bus,
    output logic [DATA_W-1:0] o_rdata,
    input wire logic [NUM_TRIG_IN-1:0] i_trig_in,
    output logic [NUM_TRIG_OUT-1:0] o_trig_out,
    output logic [NUM_IRQ-1:0] o_irq_req,
    output logic [CHSEL_W-1:0] o_adc_chsel,
    output logic o_irq
);

    // =========================================================
    // State
    tss_state_t state_q;
    tss_state_t state_d;
    logic [7:0] queue_q [QUEUE_DEPTH];
    logic [QPTR_W-1:0] qptr_q;
    logic [QPTR_W-1:0] qptr_d;
    logic [DATA_W-1:0] tgt_q [NUM_TGT];
    logic [DATA_W-1:0] adjust_q;
    logic [DATA_W-1:0] hold_q;
    logic [NUM_EVT-1:0] status_q;
    logic [NUM_EVT-1:0] mask_q;
    logic [NUM_TRIG_IN-1:0] trig_prev_q;
    logic [CHSEL_W-1:0] chsel_d;
    logic [NUM_TRIG_OUT-1:0] trig_out_d;
    logic [NUM_IRQ-1:0] irq_req_d;
    logic [NUM_EVT-1:0] status_d;
    logic [DATA_W-1:0] rdata_d;

    // =========================================================
    // Bus decode
    wire wr_ctrl = i_bus.wr && (i_bus.addr == OFS_CTRL);
    wire wr_status = i_bus.wr && (i_bus.addr == OFS_STATUS);
    wire wr_mask = i_bus.wr && (i_bus.addr == OFS_MASK);
    wire wr_adjust = i_bus.wr && (i_bus.addr == OFS_ADJUST);
    wire wr_hold = i_bus.wr && (i_bus.addr == OFS_HOLD);
    wire wr_qptr = i_bus.wr && (i_bus.addr == OFS_QPTR);
    wire wr_step = i_bus.wr && i_bus.addr[STEP_WIN_BIT];
    wire [QPTR_W-1:0] step_idx = i_bus.addr[QPTR_W+1:2];

    // =========================================================
    // Step decode
    wire running = (state_q == ST_RUN);
    wire tss_step_t step = tss_step_t'(queue_q[qptr_q]);
    wire [2:0] op_hi = step.opcode[3:1];
    wire [4:0] tgt5 = {step.opcode[0], step.option};
    wire is_ctrl = running && (step.opcode == OP_CTRL);
    wire is_addcopy = running && (step.opcode == OP_ADD_COPY);
    wire is_copy = is_addcopy && step.option[COPY_SEL_BIT];
    wire is_add = is_addcopy && !step.option[COPY_SEL_BIT];
    wire tgt_valid = (step.option[2:0] < 3'(NUM_TGT));
    wire [1:0] tgt_sel = step.option[1:0];
    wire is_strobe = running && (op_hi == OPH_STROBE);
    wire is_rise = running && (step.opcode == OP_WAIT_RISE);
    wire is_fall = running && (step.opcode == OP_WAIT_FALL);
    wire is_irq = running && (step.opcode == OP_IRQ);
    wire is_trig = running && (op_hi == OPH_TRIG);
    wire is_jump = running && (op_hi == OPH_JUMP);
    wire is_loop_a = running && (op_hi == OPH_LOOP_A);
    wire is_loop_b = running && (op_hi == OPH_LOOP_B);
    wire at_lim_a = (tgt_q[TGT_CNT_A] == tgt_q[TGT_LIM_A]);
    wire at_lim_b = (tgt_q[TGT_CNT_B] == tgt_q[TGT_LIM_B]);
    wire ctl_halt = is_ctrl && (step.option == CTL_HALT);
    wire ctl_clr_a = is_ctrl && (step.option == CTL_CLR_A);
    wire ctl_clr_b = is_ctrl && (step.option == CTL_CLR_B);

    // =========================================================
    // Trigger edge detection
    wire [NUM_TRIG_IN-1:0] rise = i_trig_in & ~trig_prev_q;
    wire [NUM_TRIG_IN-1:0] fall = ~i_trig_in & trig_prev_q;
    wire rise_hit = is_rise && rise[step.option];
    wire fall_hit = is_fall && fall[step.option];
    wire wait_done = rise_hit || fall_hit;
    wire stall = (is_rise || is_fall) && !wait_done;
    wire take_a = is_loop_a && !at_lim_a;
    wire take_b = is_loop_b && !at_lim_b;
    wire load_ptr = is_jump || take_a || take_b;

    // =========================================================
    // Next queue pointer
    assign qptr_d = wr_qptr ? i_bus.wdata[QPTR_W-1:0] :
                    !running ? qptr_q :
                    load_ptr ? tgt5 :
                    stall ? qptr_q :
                    qptr_q + 5'h01;

    // =========================================================
    // Run state
    assign state_d = wr_ctrl ? (i_bus.wdata[CTRL_RUN_BIT] ? ST_RUN : ST_IDLE) :
                     ctl_halt ? ST_IDLE : state_q;

    // =========================================================
    // Step side effects
    assign chsel_d = is_strobe ? tgt5 : o_adc_chsel;
    assign trig_out_d = is_trig ? (NUM_TRIG_OUT'(1) << tgt5) : '0;
    assign irq_req_d = is_irq ? (NUM_IRQ'(1) << step.option) : '0;

    wire [NUM_EVT-1:0] evt;
    assign evt[EVT_HALT] = ctl_halt;
    assign evt[EVT_WAIT] = wait_done;
    assign evt[EVT_IRQ] = is_irq;
    assign evt[EVT_LOOP_A] = is_loop_a && at_lim_a;
    assign evt[EVT_LOOP_B] = is_loop_b && at_lim_b;
    assign status_d = (status_q & ~(wr_status ? i_bus.wdata[NUM_EVT-1:0] : '0)) | evt;

    // =========================================================
    // Read data
    wire [DATA_W-1:0] tgt_rd = tgt_q[i_bus.addr[3:2] - 2'h1];
    wire tgt_hit = (i_bus.addr >= OFS_TGT_BASE) && (i_bus.addr < OFS_QPTR);
    assign rdata_d = !i_bus.rd ? RST_DATA :
                     i_bus.addr[STEP_WIN_BIT] ? {8'h00, queue_q[step_idx]} :
                     (i_bus.addr == OFS_CTRL) ? {15'h0000, running} :
                     (i_bus.addr == OFS_STATUS) ? {11'h000, status_q} :
                     (i_bus.addr == OFS_MASK) ? {11'h000, mask_q} :
                     (i_bus.addr == OFS_ADJUST) ? adjust_q :
                     (i_bus.addr == OFS_HOLD) ? hold_q :
                     tgt_hit ? tgt_rd :
                     (i_bus.addr == OFS_QPTR) ? {11'h000, qptr_q} :
                     (i_bus.addr == OFS_CHSEL) ? {11'h000, o_adc_chsel} :
                     RST_DATA;

    // =========================================================
    // Target registers: limits and loop counters
    genvar gi;
    generate
        for (gi = 0; gi < NUM_TGT; gi++)
        begin : g_tgt
            localparam logic [7:0] OFS = OFS_TGT_BASE + 8'(gi * 4);
            wire wr_me = i_bus.wr && (i_bus.addr == OFS);
            wire sel_me = is_addcopy && tgt_valid && (tgt_sel == 2'(gi));
            wire inc_me = ((gi == TGT_CNT_A) && take_a) || ((gi == TGT_CNT_B) && take_b);
            wire clr_me = ((gi == TGT_CNT_A) && ctl_clr_a) || ((gi == TGT_CNT_B) && ctl_clr_b);
            wire [DATA_W-1:0] nxt = wr_me ? i_bus.wdata :
                                    (sel_me && is_copy) ? hold_q :
                                    (sel_me && is_add) ? tgt_q[gi] + adjust_q :
                                    inc_me ? tgt_q[gi] + 16'h0001 :
                                    clr_me ? RST_DATA : tgt_q[gi];
            always_ff @(posedge i_clk)
            begin
                if (i_rst)
                    tgt_q[gi] <= RST_DATA;
                else if (i_ce)
                    tgt_q[gi] <= nxt;
            end
        end
    endgenerate

    // =========================================================
    // Step queue storage
    always_ff @(posedge i_clk)
    begin
        if (i_ce && wr_step)
            queue_q[step_idx] <= i_bus.wdata[7:0];
    end

    // =========================================================
    // Control and output flops
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            state_q <= ST_IDLE;
            qptr_q <= RST_QPTR;
            adjust_q <= RST_DATA;
            hold_q <= RST_DATA;
            status_q <= '0;
            mask_q <= '0;
            trig_prev_q <= '0;
            o_adc_chsel <= RST_CHSEL;
            o_trig_out <= '0;
            o_irq_req <= '0;
            o_rdata <= RST_DATA;
            o_irq <= 1'b0;
        end
        else if (i_ce)
        begin
            state_q <= state_d;
            qptr_q <= qptr_d;
            if (wr_adjust)
                adjust_q <= i_bus.wdata;
            if (wr_hold)
                hold_q <= i_bus.wdata;
            if (wr_mask)
                mask_q <= i_bus.wdata[NUM_EVT-1:0];
            status_q <= status_d;
            trig_prev_q <= i_trig_in;
            o_adc_chsel <= chsel_d;
            o_trig_out <= trig_out_d;
            o_irq_req <= irq_req_d;
            o_rdata <= rdata_d;
            o_irq <= |(status_d & (wr_mask ? i_bus.wdata[NUM_EVT-1:0] : mask_q));
        end
    end

endmodule : tss_step_sequencer
